// >>> rtl/wso_top.sv
/*
  Write-once system option register with its controlled functions:
  supply supervisor filter and hold, stop-mode entry and recovery delay,
  and the watchdog timeout. Registers sit on a classic Wishbone slave.
  Assumes supply comparator levels arrive asynchronously from pins;
  CPU strobes (stop attempt, wake, watchdog kick) share clk_i.
*/
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wso_top #(
  parameter int WDOG_SHORT_CYCLES = wso_pkg::WSO_WDOG_SHORT_CYCLES,
  parameter int WDOG_LONG_CYCLES = wso_pkg::WSO_WDOG_LONG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Supply comparators, asynchronous
  input wire logic supply_at_falling_trip_i,
  input wire logic supply_at_rising_trip_i,
  // CPU side
  input wire logic stop_mode_i,
  input wire logic stop_attempt_i,
  input wire logic stop_wake_i,
  input wire logic watchdog_kick_i,
  // Controlled functions
  output wso_pkg::wso_opts_t options_o,
  output logic supervisor_on_o,
  output logic supervisor_reset_o,
  output logic stop_enter_o,
  output logic illegal_opcode_o,
  output logic cpu_restart_o,
  output logic watchdog_enable_o,
  output logic watchdog_reset_o
);
  import wso_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic req;
  logic wr_commit;
  logic lane0;

  assign req = wb_cyc_i & wb_stb_i;
  assign lane0 = wb_sel_i[0];
  // Writes land on the ack edge, the same edge the master samples
  assign wr_commit = req & ack_q & wb_we_i;

  ////////////////////////////////////////////////////////////////////////
  // Option register, write once

  wso_opts_t opts_q;
  wso_opts_t opts_d;
  logic written_q;
  logic written_d;
  logic cfg_wr;

  assign cfg_wr = wr_commit & lane0 & (wb_adr_i == WSO_OFS_CONFIG);

  always_comb begin
    opts_d = opts_q;
    written_d = written_q;
    if (cfg_wr && !written_q) begin
      opts_d = wso_opts_t'(wb_dat_i[7:0]); // R1
      opts_d.rsvd = 1'b0;
      written_d = 1'b1; // R1
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opts_q <= wso_opts_t'(WSO_CONFIG_RESET); // R1
      written_q <= 1'b0;
    end else begin
      opts_q <= opts_d;
      written_q <= written_d;
    end
  end

  // Every option drives its function straight from the register
  assign options_o = opts_q; // R12

  ////////////////////////////////////////////////////////////////////////
  // Supply supervisor

  logic low_sync;
  logic high_sync;

  wso_sync2 u_sync_low (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(supply_at_falling_trip_i),
    .sync_o(low_sync)
  );

  wso_sync2 u_sync_high (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(supply_at_rising_trip_i),
    .sync_o(high_sync)
  );

  logic sup_active;
  wso_sup_state_t sup_q;
  wso_sup_state_t sup_d;
  logic [3:0] low_cnt_q;
  logic [3:0] low_cnt_d;

  // Stop mode drops the supervisor unless both enables are set
  assign sup_active = opts_q.sup_pwr_en // R6
    & (~stop_mode_i | opts_q.sup_stop_en); // R4

  always_comb begin
    sup_d = sup_q;
    low_cnt_d = low_cnt_q;
    unique case (sup_q)
      WSO_SUP_OFF: begin
        low_cnt_d = 4'h0;
        if (sup_active) begin
          sup_d = WSO_SUP_WATCH;
        end
      end
      WSO_SUP_WATCH: begin
        if (!sup_active) begin
          sup_d = WSO_SUP_OFF;
          low_cnt_d = 4'h0;
        end else if (!low_sync) begin
          low_cnt_d = 4'h0; // R2
        end else if (low_cnt_q == 4'(WSO_SUP_FILTER_CYCLES - 1)) begin
          sup_d = WSO_SUP_HELD; // R2
          low_cnt_d = 4'h0;
        end else begin
          low_cnt_d = low_cnt_q + 4'h1;
        end
      end
      WSO_SUP_HELD: begin
        low_cnt_d = 4'h0;
        // Release only once the supply is back above the rising trip
        if (high_sync && !low_sync) begin
          sup_d = WSO_SUP_WATCH; // R3
        end else if (!opts_q.sup_pwr_en) begin
          sup_d = WSO_SUP_OFF; // R6
        end
      end
      default: begin
        sup_d = WSO_SUP_OFF;
        low_cnt_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sup_q <= WSO_SUP_OFF;
      low_cnt_q <= 4'h0;
    end else begin
      sup_q <= sup_d;
      low_cnt_q <= low_cnt_d;
    end
  end

  assign supervisor_on_o = sup_active;
  // Request still tracked with resets off, so status stays truthful
  assign supervisor_reset_o = (sup_q == WSO_SUP_HELD) & opts_q.sup_rst_en; // R5

  ////////////////////////////////////////////////////////////////////////
  // Stop instruction and recovery

  logic stop_enter_q;
  logic stop_enter_d;
  logic illegal_q;
  logic illegal_d;

  always_comb begin
    stop_enter_d = stop_attempt_i & opts_q.stop_en; // R10
    illegal_d = stop_attempt_i & ~opts_q.stop_en; // R10
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_enter_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      stop_enter_q <= stop_enter_d;
      illegal_q <= illegal_d;
    end
  end

  assign stop_enter_o = stop_enter_q;
  assign illegal_opcode_o = illegal_q;

  logic [WSO_STOP_W-1:0] stop_len;
  logic stop_busy;
  logic [WSO_STOP_W-1:0] stop_cnt;

  // Short recovery is only safe on a clock that needs no start-up time
  assign stop_len = opts_q.short_stop_recovery
    ? WSO_STOP_W'(WSO_STOP_SHORT_CYCLES) // R7
    : WSO_STOP_W'(WSO_STOP_LONG_CYCLES); // R7

  wso_cycle_timer #(
    .W(WSO_STOP_W)
  ) u_stop_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(stop_wake_i),
    .halt_i(1'b0),
    .len_i(stop_len),
    .busy_o(stop_busy),
    .done_o(cpu_restart_o),
    .count_o(stop_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Watchdog

  logic wdog_en;
  logic wdog_busy;
  logic wdog_service;
  logic wdog_start;
  logic [WSO_WDOG_W-1:0] wdog_len;
  logic [WSO_WDOG_W-1:0] wdog_cnt;

  assign wdog_en = ~opts_q.wdog_disable; // R11
  assign wdog_service = watchdog_kick_i
    | (wr_commit & lane0 & (wb_adr_i == WSO_OFS_SERVICE));
  // Restart on every service and after each expiry
  assign wdog_start = wdog_en & (wdog_service | ~wdog_busy);
  assign wdog_len = opts_q.wdog_timeout_select
    ? WSO_WDOG_W'(WDOG_SHORT_CYCLES) // R9
    : WSO_WDOG_W'(WDOG_LONG_CYCLES); // R9

  wso_cycle_timer #(
    .W(WSO_WDOG_W)
  ) u_wdog_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(wdog_start),
    .halt_i(~wdog_en), // R11
    .len_i(wdog_len),
    .busy_o(wdog_busy),
    .done_o(watchdog_reset_o),
    .count_o(wdog_cnt)
  );

  assign watchdog_enable_o = wdog_en;

  ////////////////////////////////////////////////////////////////////////
  // Status and read mux

  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[WSO_ST_WRITTEN] = written_q;
    status[WSO_ST_SUP_HELD] = (sup_q == WSO_SUP_HELD);
    status[WSO_ST_SUP_ACTIVE] = sup_active;
    status[WSO_ST_STOP_BUSY] = stop_busy;
    status[WSO_ST_WDOG_RUN] = wdog_busy;
    status[WSO_ST_SUPPLY_LOW] = low_sync;
  end

  always_comb begin
    ack_d = req & ~ack_q;
    rdat_d = rdat_q;
    if (req && !ack_q) begin
      unique case (wb_adr_i)
        WSO_OFS_CONFIG: rdat_d = {24'h00_0000, opts_q}; // R12
        WSO_OFS_STATUS: rdat_d = {24'h00_0000, status};
        WSO_OFS_WDOG_CNT: rdat_d = {14'h0000, wdog_cnt};
        WSO_OFS_STOP_CNT: rdat_d = {19'h0_0000, stop_cnt};
        // Unmapped and write-only offsets answer with zero
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule
`default_nettype wire

// >>> rtl/wso_pkg.sv
/*
  Shared constants and types for the write-once system option block:
  register offsets, option field positions, reset value, timing counts.
  Assumes a 25 MHz clock that serves both as CPU clock and crystal clock.
*/
// Functional notes
// R1 - Reset restores default; first write accepted, later writes ignored until reset.
// R2 - Enabled supervisor resets after supply low for nine consecutive cycles.
// R3 - Supervisor reset held until supply reaches rising trip level.
// R4 - Supervisor runs in stop mode only if power and stop enables set.
// R5 - Reset enable bit passes or suppresses supervisor reset requests.
// R6 - Power enable bit switches the supervisor on or off.
// R7 - Stop wake-up delays restart 32 cycles if short recovery, else 4096.
// R8 - Software keeps short recovery clear when an external crystal is used.
// R9 - Watchdog timeout 2^13-2^4 cycles if select set, else 2^18-2^4.
// R10 - Stop enable clear makes stop an illegal opcode; set executes stop.
// R11 - Watchdog disabled when disable bit set, enabled when clear.
// R12 - All options in one readable 8-bit register driving functions continuously.
package wso_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [7:0] WSO_OFS_CONFIG = 8'h00;
  localparam logic [7:0] WSO_OFS_STATUS = 8'h04;
  localparam logic [7:0] WSO_OFS_SERVICE = 8'h08;
  localparam logic [7:0] WSO_OFS_WDOG_CNT = 8'h0C;
  localparam logic [7:0] WSO_OFS_STOP_CNT = 8'h10;

  ////////////////////////////////////////////////////////////////////////
  // Option field positions
  localparam int WSO_BIT_WDOG_DIS = 0;
  localparam int WSO_BIT_STOP_EN = 1;
  localparam int WSO_BIT_WDOG_SEL = 2;
  localparam int WSO_BIT_SHORT_STOP_RECOVERY = 3;
  localparam int WSO_BIT_SUP_PWR = 4;
  localparam int WSO_BIT_SUP_RST = 5;
  localparam int WSO_BIT_SUP_STOP = 6;

  // Status field positions
  localparam int WSO_ST_WRITTEN = 0;
  localparam int WSO_ST_SUP_HELD = 1;
  localparam int WSO_ST_SUP_ACTIVE = 2;
  localparam int WSO_ST_STOP_BUSY = 3;
  localparam int WSO_ST_WDOG_RUN = 4;
  localparam int WSO_ST_SUPPLY_LOW = 5;

  localparam logic [7:0] WSO_CONFIG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Timing, in clock cycles
  localparam int WSO_CLK_HZ = 25_000_000;
  localparam int WSO_SUP_FILTER_CYCLES = 9;
  localparam int WSO_STOP_SHORT_CYCLES = 32;
  localparam int WSO_STOP_LONG_CYCLES = 4096;
  localparam int WSO_WDOG_SHORT_CYCLES = (2 ** 13) - (2 ** 4);
  localparam int WSO_WDOG_LONG_CYCLES = (2 ** 18) - (2 ** 4);
  localparam int WSO_WDOG_W = 18;
  localparam int WSO_STOP_W = 13;

  ////////////////////////////////////////////////////////////////////////
  // Option register layout; bit 7 reserved, reads zero
  typedef struct packed {
    logic rsvd;
    logic sup_stop_en;
    logic sup_rst_en;
    logic sup_pwr_en;
    logic short_stop_recovery;
    logic wdog_timeout_select;
    logic stop_en;
    logic wdog_disable;
  } wso_opts_t;

  typedef enum logic [1:0] {
    WSO_SUP_OFF = 2'b00,
    WSO_SUP_WATCH = 2'b01,
    WSO_SUP_HELD = 2'b10
  } wso_sup_state_t;

endpackage

// >>> rtl/wso_sync2.sv
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes the input is quasi-static relative to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module wso_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// >>> rtl/wso_cycle_timer.sv
/*
  Down-counting cycle timer: load a length, pulse done when it runs out.
  Assumes start_i and halt_i come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module wso_cycle_timer #(
  parameter int W = 18
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic halt_i,
  input wire logic [W-1:0] len_i,
  output logic busy_o,
  output logic done_o,
  output logic [W-1:0] count_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic done_q;
  logic done_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (halt_i) begin
      cnt_d = '0;
    end else if (start_i) begin
      cnt_d = len_i;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
      done_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy_o = (cnt_q != '0);
  assign done_o = done_q;
  assign count_o = cnt_q;
endmodule
`default_nettype wire

// >>> test/wso_properties.sv
/*
  Port-level checker for wso_top, bound to every instance.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module wso_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire logic stop_mode_i,
  input wire logic stop_attempt_i,
  input wire wso_pkg::wso_opts_t options_o,
  input wire logic supervisor_on_o,
  input wire logic supervisor_reset_o,
  input wire logic stop_enter_o,
  input wire logic illegal_opcode_o,
  input wire logic watchdog_enable_o
);
  import wso_pkg::*;
  logic wr_d, wr_q, lock_d, lock_q;
  ////////////////////////////////////////////////////////////
  // Lock one cycle after the first config write lands
  always_comb begin
    wr_d = !rst_i && (wr_q || (wb_ack_o && wb_we_i && wb_adr_i == WSO_OFS_CONFIG && wb_sel_i[0]));
    lock_d = !rst_i && wr_q;
  end
  always_ff @(posedge clk_i) begin
    wr_q <= wr_d;
    lock_q <= lock_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o) |=> wb_ack_o)
    else $error("request not acked next cycle");
  write_once_a: assert property (lock_q |-> $stable(options_o)) else $error("options changed");
  stop_illegal_a: assert property (stop_attempt_i && !options_o.stop_en |=> illegal_opcode_o && !stop_enter_o)
    else $error("stop not refused");
  stop_enter_a: assert property (stop_attempt_i && options_o.stop_en |=> stop_enter_o && !illegal_opcode_o)
    else $error("stop not entered");
  wdog_enable_a: assert property (watchdog_enable_o == !options_o.wdog_disable) else $error("wdog enable");
  sup_power_a: assert property (supervisor_on_o ==
    (options_o.sup_pwr_en && (!stop_mode_i || options_o.sup_stop_en))) else $error("supervisor power");
  sup_gate_a: assert property (!options_o.sup_rst_en |-> !supervisor_reset_o) else $error("reset not gated");
endmodule
bind wso_top wso_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_ack_o, .stop_mode_i, .stop_attempt_i, .options_o, .supervisor_on_o, .supervisor_reset_o,
  .stop_enter_o, .illegal_opcode_o, .watchdog_enable_o);
`default_nettype wire

// >>> test/wso_top_tb.sv
/*
  Self-checking bench for wso_top with a small write-once model.
  Assumes short watchdog counts; bench drives all ports itself.
*/
`timescale 1ns/1ps
`default_nettype none
module wso_top_tb;
  import wso_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic fall = 0, rise = 0, smode = 0, satt = 0, wake = 0, kick = 0;
  logic son, srst, senter, sill, restart, wen, wrst;
  logic [7:0] adr = 8'h00, c, mdl_cfg;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  wso_opts_t opts;
  int bad_count = 0, cmp_count = 0, cyc_n = 0, mdl_done, n;
  always #20 clk_i = ~clk_i;
  wso_top #(.WDOG_SHORT_CYCLES(40), .WDOG_LONG_CYCLES(100)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .supply_at_falling_trip_i(fall), .supply_at_rising_trip_i(rise),
    .stop_mode_i(smode), .stop_attempt_i(satt), .stop_wake_i(wake), .watchdog_kick_i(kick),
    .options_o(opts), .supervisor_on_o(son), .supervisor_reset_o(srst), .stop_enter_o(senter),
    .illegal_opcode_o(sill), .cpu_restart_o(restart), .watchdog_enable_o(wen), .watchdog_reset_o(wrst));
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard; run needs about 9k cycles
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_lat(input int k, input int lo, input int hi);
    cmp_count++;
    if (k < lo || k > hi) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, k, lo);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic do_rst();
    tick(1);
    rst_i <= 1'b1;
    tick(4);
    rst_i <= 1'b0;
    mdl_cfg = WSO_CONFIG_RESET;
    mdl_done = 0;
  endtask
  // Ack sampled at the rising edge, before that edge's own update lands
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [31:0] e);
    tick(1);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (!w) chk(rdat, e);
    else if (a == WSO_OFS_CONFIG && mdl_done == 0) begin
      mdl_cfg = d;
      mdl_done = 1;
    end
  endtask
  task automatic pulse(input int w);
    tick(1);
    satt <= (w == 0);
    wake <= (w == 1);
    kick <= (w == 2);
    tick(1);
    satt <= 1'b0;
    wake <= 1'b0;
    kick <= 1'b0;
  endtask
  task automatic wait_hi(input int w, input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while ((w == 0 ? restart : w == 1 ? wrst : srst) !== 1'b1 && k < lim);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    c = $urandom(32'h3da0efef);
    for (int i = 0; i < 4; i++) begin
      do_rst();
      acc(0, WSO_OFS_CONFIG, 0, mdl_cfg);
      chk(son, 0);
      acc(0, WSO_OFS_STATUS, 0, 32'(1) << WSO_ST_WDOG_RUN);
      c = $urandom;
      c[0] = (i == 3);
      c[1] = i[0] ^ i[1];
      c[2] = i[1];
      c[3] = i[0];
      c[4] = 1'b1;
      c[5] = !i[0];
      c[7] = 1'b0;
      acc(1, WSO_OFS_CONFIG, c, 0);
      acc(1, WSO_OFS_CONFIG, ~c, 0);
      acc(0, WSO_OFS_CONFIG, 0, mdl_cfg);
      acc(0, 8'h20, 0, 0);
      chk(opts, c);
      chk(wen, !c[0]);
      tick(1);
      smode <= 1'b1;
      @(negedge clk_i);
      chk(son, c[6]);
      tick(1);
      smode <= 1'b0;
      @(negedge clk_i);
      chk(son, 1);
      pulse(0);
      @(negedge clk_i);
      chk({senter, sill}, {c[1], !c[1]});
      pulse(1);
      wait_hi(0, 5000, n);
      chk_lat(n, c[3] ? 32 : 4096, c[3] ? 34 : 4098);
      if (i[0]) acc(1, WSO_OFS_SERVICE, 0, 0);
      else pulse(2);
      wait_hi(1, 300, n);
      if (c[0]) chk_lat(n, 300, 300);
      else chk_lat(n, c[2] ? 38 : 98, c[2] ? 42 : 102);
      tick(1);
      fall <= 1'b1;
      tick(8);
      fall <= 1'b0;
      wait_hi(2, 20, n);
      chk_lat(n, 20, 20);
      tick(1);
      fall <= 1'b1;
      wait_hi(2, 40, n);
      if (c[5]) chk_lat(n, 9, 16);
      else chk_lat(n, 40, 40);
      tick(1);
      fall <= 1'b0;
      tick(10);
      @(negedge clk_i);
      chk(srst, c[5]);
      tick(1);
      rise <= 1'b1;
      tick(6);
      @(negedge clk_i);
      chk(srst, 0);
      tick(1);
      rise <= 1'b0;
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
